// ### hw/dofs_top.sv
// drive output function select: five digital output routers, analog polarity
// assumes synchronous status inputs from the regulator core and an axi4-lite master
//
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "dofs_cfg.svh"
`default_nettype none
module dofs_top #(
  parameter int TICK_CYCLES = `DOFS_CLK_HZ / 1000 * `DOFS_TICK_MS
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  // axi4-lite slave
  input  wire logic [6:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [6:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // drive status from the regulator core
  input  wire logic                      drive_ok,
  input  wire logic signed [15:0]        speed_feedback_monitor,
  input  wire logic signed [15:0]        armature_current,
  input  wire logic [15:0]               field_current,
  input  wire logic signed [15:0]        reference_error,
  input  wire logic signed [15:0]        ramp_input_error,
  input  wire logic                      current_limit,
  input  wire logic                      drive_running,
  input  wire logic                      current_overlimit,
  input  wire logic                      field_weakening,
  input  wire logic                      no_warning,
  input  wire logic [`DOFS_NUM_OUT-1:0]  fieldbus_bit,
  input  wire logic                      timer_input_a,
  input  wire logic                      timer_input_b,
  input  wire logic                      output1_mode_jumper,
  input  wire logic                      output2_mode_jumper,
  // terminal side
  output logic [`DOFS_NUM_OUT-1:0]       multifunction_digital_output,
  output logic                           current_output_unipolar,
  output logic [1:0]                     voltage_output_unipolar
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // magnitude of a signed monitor value
  function automatic logic [15:0] dofs_abs(input logic signed [15:0] v);
    dofs_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction : dofs_abs
  // byte-lane merge for partial writes
  function automatic logic [31:0] dofs_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    dofs_merge = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        dofs_merge[b*8 +: 8] = new_v[b*8 +: 8];
  endfunction : dofs_merge

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]                                 polarity;      // analog polarity bits
  logic [`DOFS_NUM_OUT*`DOFS_CODE_W-1:0]      function_code; // packed selectors
  logic [`DOFS_NUM_OUT-1:0]                   output_sense;  // output_logic_sense
  logic [`DOFS_DLY_W-1:0]                     overlimit_time;// overlimit_time_setting, ms
  logic [`DOFS_DLY_W-1:0]                     on_dly  [`DOFS_NUM_OUT];
  logic [`DOFS_DLY_W-1:0]                     off_dly [`DOFS_NUM_OUT];
  logic [`DOFS_LVL_W-1:0]                     level   [`DOFS_NUM_OUT];
  logic                                       overlimit_done;// code 6 source
  logic [31:0]                                wmerge;        // merged write value
  logic [31:0]                                next_rdata;    // read mux
  logic                                       wr_ok;         // mapped write offset
  logic                                       rd_ok;         // mapped read offset
  logic                                       wr_fire;       // write taken
  logic [`DOFS_NUM_OUT*`DOFS_CODE_W-1:0]      next_func;     // range-checked codes

  // ----------------------------------------------------------------
  // axi4-lite handshake
  // ----------------------------------------------------------------
  // address and data taken together; no new write while a response waits
  // ready stays low while frozen, so a master never sees a beat that was not taken
  assign s_axi_awready = !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid && clk_en;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid && clk_en;

  // decode of the word offsets that exist
  always_comb
  begin
    wr_ok = (s_axi_awaddr[6:5] != 2'h0) ||
            (s_axi_awaddr < `DOFS_OFS_STATUS);
    rd_ok = (s_axi_araddr[6:5] != 2'h0) ||
            (s_axi_araddr <= `DOFS_OFS_STATUS);
    if (s_axi_awaddr[6:5] != 2'h0)
      wr_ok = s_axi_awaddr[4:2] < 3'(`DOFS_NUM_OUT);
    if (s_axi_araddr[6:5] != 2'h0)
      rd_ok = s_axi_araddr[4:2] < 3'(`DOFS_NUM_OUT);
  end

  // write response channel
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DOFS_RESP_OK;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `DOFS_RESP_OK : `DOFS_RESP_ERR; // unmapped or read-only
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read mux; bits above each field read as zero
  always_comb
  begin
    next_rdata = 32'h0;
    case (s_axi_araddr[6:5])
      2'h0:
        case (s_axi_araddr[4:2])
          3'h0:    next_rdata[2:0] = polarity;
          3'h1:    next_rdata[19:0] = function_code;
          3'h2:    next_rdata[4:0] = output_sense;
          3'h3:    next_rdata[19:0] = overlimit_time;
          3'h4:    next_rdata[5:0] = {overlimit_done, multifunction_digital_output};
          default: next_rdata = 32'h0;
        endcase
      2'h1:    next_rdata[19:0] = rd_ok ? on_dly[s_axi_araddr[4:2]] : 20'h0;
      2'h2:    next_rdata[19:0] = rd_ok ? off_dly[s_axi_araddr[4:2]] : 20'h0;
      default: next_rdata[7:0] = rd_ok ? level[s_axi_araddr[4:2]] : 8'h0;
    endcase
  end

  // read data channel, answer one cycle after the address is taken
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `DOFS_RESP_OK;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rd_ok ? `DOFS_RESP_OK : `DOFS_RESP_ERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // the merge picks the register that the write address names
  always_comb
  begin
    wmerge = 32'h0;
    case (s_axi_awaddr[6:5])
      2'h0:
        case (s_axi_awaddr[4:2])
          3'h0:    wmerge = dofs_merge({29'h0, polarity}, s_axi_wdata, s_axi_wstrb);
          3'h1:    wmerge = dofs_merge({12'h0, function_code}, s_axi_wdata, s_axi_wstrb);
          3'h2:    wmerge = dofs_merge({27'h0, output_sense}, s_axi_wdata, s_axi_wstrb);
          default: wmerge = dofs_merge({12'h0, overlimit_time}, s_axi_wdata, s_axi_wstrb);
        endcase
      2'h1:    wmerge = dofs_merge({12'h0, on_dly[s_axi_awaddr[4:2]]}, s_axi_wdata,
                                   s_axi_wstrb);
      2'h2:    wmerge = dofs_merge({12'h0, off_dly[s_axi_awaddr[4:2]]}, s_axi_wdata,
                                   s_axi_wstrb);
      default: wmerge = dofs_merge({24'h0, level[s_axi_awaddr[4:2]]}, s_axi_wdata,
                                   s_axi_wstrb);
    endcase
    // a selector nibble above the last code keeps its old value
    for (int i = 0; i < `DOFS_NUM_OUT; i++)
      next_func[i*`DOFS_CODE_W +: `DOFS_CODE_W] =
        (wmerge[i*`DOFS_CODE_W +: `DOFS_CODE_W] > `DOFS_CODE_MAX) ?
        function_code[i*`DOFS_CODE_W +: `DOFS_CODE_W] :
        wmerge[i*`DOFS_CODE_W +: `DOFS_CODE_W];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      polarity       <= `DOFS_POL_RST;
      function_code  <= `DOFS_FUNC_RST;
      output_sense   <= `DOFS_SENSE_RST;
      overlimit_time <= '0;
      for (int i = 0; i < `DOFS_NUM_OUT; i++)
      begin
        on_dly[i]  <= '0;
        off_dly[i] <= '0;
        level[i]   <= $bits(level[i])'(`DOFS_LVL_RST >> (i*`DOFS_LVL_W));
      end
    end
    else if (wr_fire && wr_ok)
    begin
      case (s_axi_awaddr[6:5])
        2'h0:
          case (s_axi_awaddr[4:2])
            3'h0:    polarity       <= wmerge[2:0];
            3'h1:    function_code  <= next_func;
            3'h2:    output_sense   <= wmerge[4:0];
            default: overlimit_time <= wmerge[19:0];
          endcase
        2'h1:    on_dly[s_axi_awaddr[4:2]]  <= wmerge[19:0];
        2'h2:    off_dly[s_axi_awaddr[4:2]] <= wmerge[19:0];
        default: level[s_axi_awaddr[4:2]]   <= wmerge[7:0];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog polarity
  // ----------------------------------------------------------------
  // a jumper in current mode gives 0..20 ma, always one direction
  assign current_output_unipolar    = polarity[`DOFS_POL_CUR];
  assign voltage_output_unipolar[0] = output1_mode_jumper | polarity[`DOFS_POL_V1];
  assign voltage_output_unipolar[1] = output2_mode_jumper | polarity[`DOFS_POL_V2];

  // ----------------------------------------------------------------
  // millisecond tick and overlimit timer
  // ----------------------------------------------------------------
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;   // prescaler
  logic                             tick;       // one-cycle ms strobe
  logic [`DOFS_DLY_W-1:0]           ovl_cnt;    // ms spent in overlimit

  assign tick = (tick_cnt == '0);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else if (clk_en)
      tick_cnt <= tick ? $bits(tick_cnt)'(TICK_CYCLES - 1) : tick_cnt - 1'b1;
  end

  // leaving overlimit restarts the wait, so only an unbroken stretch counts
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovl_cnt        <= '0;
      overlimit_done <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!current_overlimit)
      begin
        ovl_cnt        <= '0;
        overlimit_done <= 1'b0;
      end
      else
      begin
        if (tick && ovl_cnt < overlimit_time)
          ovl_cnt <= ovl_cnt + 1'b1;
        overlimit_done <= (ovl_cnt >= overlimit_time);
      end
    end
  end

  AST_OVL_NEEDS_INPUT: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(overlimit_done) |-> $past(current_overlimit) &&
    $past(ovl_cnt) >= $past(overlimit_time))
    else $error("overlimit flag rose without overlimit");

  // ----------------------------------------------------------------
  // per-output selection and delay shaping
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `DOFS_NUM_OUT; g++)
    begin : g_out
      logic [`DOFS_NUM_CODES-1:0] cond;     // candidate sources
      logic [`DOFS_CODE_W-1:0]    code;     // this output's selector
      logic [15:0]                lvl;      // level widened to compare
      logic                       request;  // selected source
      logic [`DOFS_DLY_W-1:0]     dcnt;     // delay count in ms
      dofs_pkg::dofs_state_t      state;    // shaper state

      assign code = function_code[g*`DOFS_CODE_W +: `DOFS_CODE_W];
      assign lvl  = {8'h0, level[g]};

      // source conditions, thresholds against this output's level
      always_comb
      begin
        cond                = '0;
        cond[`DOFS_C_OK]    = drive_ok;
        cond[`DOFS_C_SPD]   = dofs_abs(speed_feedback_monitor) > lvl;
        cond[`DOFS_C_ARM]   = dofs_abs(armature_current) > lvl;
        cond[`DOFS_C_ATSPD] = drive_running &&
                              dofs_abs(ramp_input_error) < lvl;
        cond[`DOFS_C_ILIM]  = current_limit;
        cond[`DOFS_C_RUN]   = drive_running;
        cond[`DOFS_C_OVL]   = overlimit_done;
        cond[`DOFS_C_FWK]   = field_weakening;
        cond[`DOFS_C_FLD]   = field_current > lvl;
        cond[`DOFS_C_REF]   = dofs_abs(reference_error) > lvl;
        cond[`DOFS_C_NOWARN] = no_warning;
        cond[`DOFS_C_BUS]   = fieldbus_bit[g];
        cond[`DOFS_C_TMA]   = timer_input_a;
        cond[`DOFS_C_TMB]   = timer_input_b;
        request = (code <= `DOFS_CODE_MAX) ? cond[code] : 1'b0;
      end

      // on delay from the moment the source turns true, off delay likewise
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state <= dofs_pkg::DOFS_OFF;
          dcnt  <= '0;
        end
        else if (clk_en)
        begin
          case (state)
            dofs_pkg::DOFS_OFF:
              if (request)
              begin
                state <= (on_dly[g] == '0) ? dofs_pkg::DOFS_ON : dofs_pkg::DOFS_ON_WAIT;
                dcnt  <= '0;
              end
            dofs_pkg::DOFS_ON_WAIT:
              if (!request)
                state <= dofs_pkg::DOFS_OFF;       // glitch shorter than the delay
              else if (dcnt >= on_dly[g])
                state <= dofs_pkg::DOFS_ON;
              else if (tick)
                dcnt <= dcnt + 1'b1;
            dofs_pkg::DOFS_ON:
              if (!request)
              begin
                state <= (off_dly[g] == '0) ? dofs_pkg::DOFS_OFF : dofs_pkg::DOFS_OFF_WAIT;
                dcnt  <= '0;
              end
            dofs_pkg::DOFS_OFF_WAIT:
              if (request)
                state <= dofs_pkg::DOFS_ON;
              else if (dcnt >= off_dly[g])
                state <= dofs_pkg::DOFS_OFF;
              else if (tick)
                dcnt <= dcnt + 1'b1;
            default:
              state <= dofs_pkg::DOFS_OFF;
          endcase
        end
      end

      // relay is energised while on or waiting to drop; sense inverts it
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
          multifunction_digital_output[g] <= 1'b0;
        else if (clk_en)
          multifunction_digital_output[g] <= output_sense[g] ^
            (state == dofs_pkg::DOFS_ON || state == dofs_pkg::DOFS_OFF_WAIT);
      end

      AST_CODE_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        code <= `DOFS_CODE_MAX)
        else $error("selector holds an undefined code");
      AST_AT_SPEED_RUN: assert property (@(posedge clock) disable iff (!rst_n)
        cond[`DOFS_C_ATSPD] |-> drive_running)
        else $error("at speed without running");
      AST_BUS_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
        code == `DOFS_C_BUS |-> request == fieldbus_bit[g])
        else $error("fieldbus code not routed");
      AST_NO_DELAY_ON: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state == dofs_pkg::DOFS_OFF && request && on_dly[g] == '0 ##1 clk_en
        |=> multifunction_digital_output[g] == !output_sense[g])
        else $error("zero on delay did not switch in two cycles");
      AST_ON_WAIT_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
        clk_en && state == dofs_pkg::DOFS_ON_WAIT && request && dcnt < on_dly[g]
        |=> state != dofs_pkg::DOFS_ON)
        else $error("output on before its delay");
    end
  endgenerate

  AST_CUR_MODE: assert property (@(posedge clock) disable iff (!rst_n)
    output1_mode_jumper |-> voltage_output_unipolar[0])
    else $error("current mode output not unidirectional");
  AST_V_POL: assert property (@(posedge clock) disable iff (!rst_n)
    wr_fire && wr_ok && s_axi_awaddr == `DOFS_OFS_POLARITY && s_axi_wstrb[0]
    && !output2_mode_jumper
    |=> voltage_output_unipolar[1] == $past(s_axi_wdata[`DOFS_POL_V2]))
    else $error("voltage polarity write not applied");
  AST_BVALID_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule : dofs_top
`default_nettype wire

// ### hw/dofs_cfg.svh
// constants for the drive output function select block
// assumes inclusion by bare name from the bench and the top module
`ifndef DOFS_CFG_SVH
`define DOFS_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DOFS_OFS_POLARITY  7'h00
`define DOFS_OFS_FUNCTION  7'h04
`define DOFS_OFS_SENSE     7'h08
`define DOFS_OFS_OVERLIMIT 7'h0c
`define DOFS_OFS_STATUS    7'h10
`define DOFS_OFS_ON_BASE   7'h20
`define DOFS_OFS_OFF_BASE  7'h40
`define DOFS_OFS_LVL_BASE  7'h60
// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define DOFS_NUM_OUT       5
`define DOFS_CODE_W        4
`define DOFS_DLY_W         20
`define DOFS_LVL_W         8
`define DOFS_POL_CUR       0
`define DOFS_POL_V1        1
`define DOFS_POL_V2        2
`define DOFS_POL_RST       3'h0
`define DOFS_FUNC_RST      20'h45210
`define DOFS_SENSE_RST     5'h00
`define DOFS_CODE_MAX      4'hd
`define DOFS_NUM_CODES     14
`define DOFS_LVL_RST       40'h3205320332
// ----------------------------------------------------------------
// function codes and timing
// ----------------------------------------------------------------
`define DOFS_C_OK 0
`define DOFS_C_SPD 1
`define DOFS_C_ARM 2
`define DOFS_C_ATSPD 3
`define DOFS_C_ILIM 4
`define DOFS_C_RUN 5
`define DOFS_C_OVL 6
`define DOFS_C_FWK 7
`define DOFS_C_FLD 8
`define DOFS_C_REF 9
`define DOFS_C_NOWARN 10
`define DOFS_C_BUS 11
`define DOFS_C_TMA 12
`define DOFS_C_TMB 13
`define DOFS_CLK_HZ        100000000
`define DOFS_TICK_MS       1
`define DOFS_RESP_OK       2'h0
`define DOFS_RESP_ERR      2'h2
`endif

// ### hw/dofs_pkg.sv
// types shared by the drive output function select block
// assumes the cfg header is on the include path
`default_nettype none
package dofs_pkg;
  // one-hot state of each output's on/off delay shaper
  typedef enum logic [3:0] {
    DOFS_OFF      = 4'h1,
    DOFS_ON_WAIT  = 4'h2,
    DOFS_ON       = 4'h4,
    DOFS_OFF_WAIT = 4'h8
  } dofs_state_t;
endpackage : dofs_pkg
`default_nettype wire

// ### tb/tb.sv
// bench for the drive output function select block
// assumes dofs_top and the cfg header on the include path, one 100 mhz clock
`include "dofs_cfg.svh"
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, clk_en;
  logic [6:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, voltage_output_unipolar;
  logic drive_ok, current_limit, drive_running, current_overlimit, field_weakening;
  logic no_warning, timer_input_a, timer_input_b, output1_mode_jumper, output2_mode_jumper;
  logic signed [15:0] speed_feedback_monitor, armature_current, reference_error;
  logic signed [15:0] ramp_input_error;
  logic [15:0] field_current;
  logic [4:0] fieldbus_bit, multifunction_digital_output;
  logic current_output_unipolar;
  logic [3:0] act;          // which source condition is made true, 15 = none
  logic [31:0] rdat;        // last read word
  logic [1:0] resp;         // last response code
  int errors, check_count;
  dofs_top #(.TICK_CYCLES(4)) u_dofs_top (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .drive_ok(drive_ok),
    .speed_feedback_monitor(speed_feedback_monitor), .armature_current(armature_current),
    .field_current(field_current), .reference_error(reference_error),
    .ramp_input_error(ramp_input_error), .current_limit(current_limit),
    .drive_running(drive_running), .current_overlimit(current_overlimit),
    .field_weakening(field_weakening), .no_warning(no_warning), .fieldbus_bit(fieldbus_bit),
    .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
    .output1_mode_jumper(output1_mode_jumper), .output2_mode_jumper(output2_mode_jumper),
    .multifunction_digital_output(multifunction_digital_output),
    .current_output_unipolar(current_output_unipolar),
    .voltage_output_unipolar(voltage_output_unipolar));
  // ----------------------------------------------------------------
  // clock, reset and source stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // one condition at a time, but at speed also sets running; speed and reference negative to exercise the absolute value
  always @(posedge clock)
  begin
    drive_ok <= act == 0;
    speed_feedback_monitor <= (act == 1) ? -16'sd100 : 16'sd0;
    armature_current <= (act == 2) ? 16'sd100 : 16'sd0;
    ramp_input_error <= (act == 3) ? 16'sd0 : 16'sd100;
    current_limit <= act == 4;
    drive_running <= act == 3 || act == 5;
    current_overlimit <= act == 6;
    field_weakening <= act == 7;
    field_current <= (act == 8) ? 16'h0064 : 16'h0000;
    reference_error <= (act == 9) ? -16'sd100 : 16'sd0;
    no_warning <= act == 10;
    fieldbus_bit <= (act == 11) ? 5'h1f : 5'h00;
    timer_input_a <= act == 12;
    timer_input_b <= act == 13;
  end
  // ----------------------------------------------------------------
  // bus tasks: hold every channel until its ready or valid is seen
  // ----------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 0; s_axi_wvalid <= 0;
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    rdat = s_axi_rdata; resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask : rd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(`DOFS_OFS_POLARITY); `CHK("pol", 32'h0, rdat)
    rd(`DOFS_OFS_FUNCTION); `CHK("func", 32'h45210, rdat)
    rd(7'h7c); `CHK("unmapped", 2'h2, resp)
    $display("test reset done");
  endtask : t_reset
  task automatic t_polarity;
    wr(`DOFS_OFS_POLARITY, 32'h5); repeat (2) @(posedge clock);
    `CHK("cur", 1'b1, current_output_unipolar)
    `CHK("volt", 2'b10, voltage_output_unipolar)
    output1_mode_jumper <= 1; repeat (2) @(posedge clock);
    `CHK("jump", 2'b11, voltage_output_unipolar)
    output1_mode_jumper <= 0; wr(`DOFS_OFS_POLARITY, 32'h0); repeat (2) @(posedge clock);
    `CHK("bip", 3'h0, {current_output_unipolar, voltage_output_unipolar})
    $display("test polarity done");
  endtask : t_polarity
  // every code on output 1: asserts with its own source, drops with none
  task automatic t_codes;
    for (int c = 0; c < 14; c++)
    begin
      act <= c[3:0]; wr(`DOFS_OFS_FUNCTION, {12'h0, 16'h4521, c[3:0]});
      repeat (12) @(posedge clock);
      `CHK("on", 1'b1, multifunction_digital_output[0])
      act <= 4'hf; repeat (12) @(posedge clock);
      `CHK("off", 1'b0, multifunction_digital_output[0])
    end
    wr(`DOFS_OFS_FUNCTION, 32'h4521e); rd(`DOFS_OFS_FUNCTION);
    `CHK("keep", 32'h4521d, rdat)
    $display("test codes done");
  endtask : t_codes
  task automatic t_delay;
    wr(`DOFS_OFS_FUNCTION, 32'h4521c); wr(`DOFS_OFS_ON_BASE, 32'h2);
    act <= 4'hc; repeat (6) @(posedge clock);
    `CHK("wait", 1'b0, multifunction_digital_output[0])
    repeat (20) @(posedge clock);
    `CHK("late", 1'b1, multifunction_digital_output[0])
    clk_en <= 0; act <= 4'hf; repeat (10) @(posedge clock);
    `CHK("frozen", 1'b1, multifunction_digital_output[0])
    clk_en <= 1; repeat (10) @(posedge clock);
    `CHK("released", 1'b0, multifunction_digital_output[0])
    $display("test delay done");
  endtask : t_delay
  // overlimit must last the set time before code 6 switches
  task automatic t_overlimit;
    wr(`DOFS_OFS_ON_BASE, 32'h0); wr(`DOFS_OFS_OVERLIMIT, 32'h3);
    wr(`DOFS_OFS_FUNCTION, 32'h45216); act <= 4'h6; repeat (8) @(posedge clock);
    `CHK("ovl early", 1'b0, multifunction_digital_output[0])
    repeat (22) @(posedge clock);
    `CHK("ovl late", 1'b1, multifunction_digital_output[0])
    rd(`DOFS_OFS_STATUS); `CHK("ovl status", 1'b1, rdat[5])
    $display("test overlimit done");
  endtask : t_overlimit
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  initial
  begin
    #100us;
    errors++;
    results();
  end
  initial
  begin
    rst_n = 0; clk_en = 1; act = 4'hf; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0;
    s_axi_wstrb = 4'hf; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0;
    s_axi_arvalid = 0; s_axi_rready = 0; output1_mode_jumper = 0; output2_mode_jumper = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1;
    t_reset(); t_polarity(); t_codes(); t_delay(); t_overlimit();
    results();
  end
endmodule : tb
`default_nettype wire
